// ===== include/nes_consts.vh
// constants for the neighbour entry store
`ifndef NES_CONSTS_VH
`define NES_CONSTS_VH
`define NES_ENTRIES        8
`define NES_IDX_W          3
`define NES_ADDR_W         16
`define NES_MASK_W         24
`define NES_CONST_W        3
`define NES_GAIN_W         4
`define NES_COEF_W         48
`define NES_LQI_W          8
`define NES_PHASE_W        3
`define NES_VALID_W        8
`define NES_SCHEME_DIFF    1'h0
`define NES_SCHEME_COH     1'h1
`define NES_CONST_ROBUST   3'h0
`define NES_CONST_QAM16    3'h4
`define NES_CONST_MAX      3'h4
// packed entry layout, lsb first
`define NES_F_ADDR_LSB     0
`define NES_F_SCHEME       16
`define NES_F_MASK_LSB     17
`define NES_F_CONST_LSB    41
`define NES_F_GAIN_LSB     44
`define NES_F_RES          48
`define NES_F_COEF_LSB     49
`define NES_F_LQI_LSB      97
`define NES_F_PHASE_LSB    105
`define NES_F_VALID_LSB    108
`define NES_ENTRY_W        116
`define NES_STATIC_W       108
`endif

// ===== sim/neighbour_entry_store_tb.sv
// self-checking bench for the neighbour entry store
`timescale 1ns/1ps
module neighbour_entry_store_tb;
  reg           clk = 0, rst_n = 0, coh = 0, qam = 0, cr = 0;
  reg   [5:0]   st = 0;
  reg   [2:0]   ix = 0;
  reg   [7:0]   dv = 0, ml = 0;
  reg   [115:0] wd = 0, m [0:7];
  wire  [115:0] rdat, tx;
  wire          rj, mr, mt, rv, tv;
  integer       err_count = 0, cmp_count = 0, i, j;
  always #50 clk = ~clk;
  nes_tick_partner tp_u (.clk(clk), .rst_n(rst_n), .tick_req(st[5]), .minute_tick(mt));
  nes_store dut_u (.clk(clk), .rst_n(rst_n), .default_validity(dv), .map_response_lifetime(ml),
    .coherent_supported(coh), .qam16_supported(qam), .minute_tick(mt), .mgmt_wr(st[0]),
    .mgmt_create(cr), .mgmt_rd(st[1]), .mgmt_idx(ix), .mgmt_wdata(wd), .mgmt_rvalid_q(rv),
    .mgmt_rdata_q(rdat), .mgmt_reject_q(rj), .map_response_ok(st[3]), .event_idx(ix),
    .retry_limit_fail(st[4]), .tx_lookup(st[2]), .tx_idx(ix), .tx_valid_q(tv),
    .tx_scheme_q(tx[16]), .tx_short_addr_q(tx[15:0]), .tx_subcarrier_group_mask_q(tx[40:17]),
    .tx_map_request_q(mr),
    .tx_constellation_select_q(tx[43:41]), .tx_transmit_amplification_q(tx[47:44]),
    .tx_gain_step_resolution_q(tx[48]), .tx_per_group_gain_steps_q(tx[96:49]),
    .tx_return_link_quality_q(tx[104:97]), .tx_mains_phase_offset_q(tx[107:105]),
    .tx_param_validity_minutes_q(tx[115:108]));
  task chk(input [115:0] s, input [115:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e) $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    err_count = err_count + (s !== e);
  endtask
  task pl(input [5:0] s, input [2:0] x);
    @(posedge clk) {st, ix} <= {s, x};
    @(posedge clk) st <= 6'h00;
    @(negedge clk);
  endtask
  task vr(input [2:0] x);
    pl(6'h06, x);
    chk(rv, 1'b1);
    chk(rdat, m[x]);
    chk(tv, 1'b1);
    chk(tx, m[x]);
    chk(mr, m[x][115:108] == 8'h00);
  endtask
  task wrt(input [2:0] x, input [115:0] d, input c, input h, input q);
    reg bad;
    bad = d[43:41] > 3'h4 || (d[43:41] == 3'h4 && !(d[16] && q)) || (d[16] && !h);
    @(posedge clk) {wd, cr, coh, qam} <= {d, c, h, q};
    pl(6'h01, x);
    chk(rj, bad);
    chk({rv, tv}, 2'h0);
    if (!bad) m[x] = c ? {dv, d[107:0]} : d;
  endtask
  // the partner delays the tick by one cycle, so the model steps one edge later
  task tick;
    pl(6'h20, 3'h0);
    @(negedge clk);
    for (j = 0; j < 8; j = j + 1) m[j][115:108] = m[j][115:108] - |m[j][115:108];
  endtask
  task close_out;
    if (err_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {ml, dv} <= 16'($urandom(79091));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 56; i = i + 1)
      wrt(i < 8 ? i[2:0] : 3'($urandom), 116'({$urandom, $urandom, $urandom, $urandom})
        & ~(i < 8 ? 116'h800_0001_0000 : 116'h0), i < 8, 1'($urandom), 1'($urandom));
    wrt(3'h3, {8'h01, 108'h5A5_0000_1234}, 1'b0, 1'b0, 1'b0);
    repeat (2) tick;
    for (i = 0; i < 8; i = i + 1) vr(i[2:0]);
    pl(6'h08, 3'h3);
    m[3][115:108] = ml;
    vr(3'h3);
    pl(6'h18, 3'h3);
    m[3][115:108] = 8'h00;
    vr(3'h3);
    close_out;
  end
  initial
  begin
    #1000000 err_count = err_count + 1;
    close_out;
  end
endmodule

// ===== sim/nes_store_asserts.sv
// port assertions for the neighbour entry store
`timescale 1ns/1ps
module nes_store_asserts (
  // watched store ports
  input wire         clk,
  input wire         rst_n,
  input wire         mgmt_wr,
  input wire         mgmt_rd,
  input wire [115:0] mgmt_wdata,
  input wire         mgmt_rvalid_q,
  input wire         mgmt_reject_q,
  input wire         tx_lookup,
  input wire         tx_valid_q,
  input wire [7:0]   tx_param_validity_minutes_q,
  input wire         tx_map_request_q);
  wire [2:0] cst = mgmt_wdata[43:41];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd; mgmt_rd ##1 mgmt_rvalid_q; endsequence
  sequence s_lk; tx_lookup ##1 tx_valid_q; endsequence
  rd_answer_a: assert property (mgmt_rd |-> s_rd) else $error("read unanswered");
  rd_pulse_a: assert property (!mgmt_rd |=> !mgmt_rvalid_q) else $error("stray rvalid");
  tx_answer_a: assert property (tx_lookup |-> s_lk) else $error("lookup unanswered");
  tx_pulse_a: assert property (!tx_lookup |=> !tx_valid_q) else $error("stray tx valid");
  rsv_reject_a: assert property (mgmt_wr && cst > 3'h4 |=> mgmt_reject_q)
    else $error("reserved kept");
  qam_reject_a: assert property (mgmt_wr && cst == 3'h4 && !mgmt_wdata[16] |=> mgmt_reject_q)
    else $error("qam kept");
  rej_pulse_a: assert property (!mgmt_wr |=> !mgmt_reject_q) else $error("stray reject");
  map_flag_a: assert property (tx_valid_q |-> tx_map_request_q == !tx_param_validity_minutes_q)
    else $error("map flag wrong");
endmodule
bind nes_store nes_store_asserts chk_u (.clk(clk), .rst_n(rst_n), .mgmt_wr(mgmt_wr),
  .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rvalid_q(mgmt_rvalid_q),
  .mgmt_reject_q(mgmt_reject_q), .tx_lookup(tx_lookup), .tx_valid_q(tx_valid_q),
  .tx_param_validity_minutes_q(tx_param_validity_minutes_q), .tx_map_request_q(tx_map_request_q));

// ===== sim/nes_tick_partner.sv
// partner: minute timebase that turns a request into a tick pulse
`timescale 1ns/1ps
module nes_tick_partner (
  // timebase pins
  input  wire clk,
  input  wire rst_n,
  input  wire tick_req,
  output reg  minute_tick);
  // registered, so a tick never lands in the cycle it was asked for
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      minute_tick <= 1'b0;
    else
      minute_tick <= tick_req;
  end
endmodule

// ===== src/nes_store.v
// neighbour entry store with management and transmit ports
`timescale 1ns/1ps
`include "nes_consts.vh"
//
// Overview of operation
// - entry holds 16-bit neighbour short address
// - one-bit scheme: differential or coherent
// - entry holds 24-bit subcarrier group mask
// - 3-bit constellation select, 5-7 reserved
// - 16-QAM only with coherent scheme
// - entry holds 4-bit transmit amplification
// - gain step resolution: 6 dB or 3 dB
// - 48-bit per-group gain steps, two bits each
// - entry holds 8-bit return link quality
// - 3-bit mains phase offset, 60-degree steps
// - 8-bit validity countdown in minutes
// - creation loads default validity value
// - expired entry flags map request need
// - map response reloads configured lifetime
// - retry limit failure zeroes validity
// - whole store readable, writable by management
//
module nes_store
(
  // clock and reset
  input  wire                          clk,
  input  wire                          rst_n,
  // configuration
  input  wire [`NES_VALID_W-1:0]       default_validity,
  input  wire [`NES_VALID_W-1:0]       map_response_lifetime,
  input  wire                          coherent_supported,
  input  wire                          qam16_supported,
  input  wire                          minute_tick,
  // management access to the attribute
  input  wire                          mgmt_wr,
  input  wire                          mgmt_create,
  input  wire                          mgmt_rd,
  input  wire [`NES_IDX_W-1:0]         mgmt_idx,
  input  wire [`NES_ENTRY_W-1:0]       mgmt_wdata,
  output reg                           mgmt_rvalid_q,
  output reg  [`NES_ENTRY_W-1:0]       mgmt_rdata_q,
  output reg                           mgmt_reject_q,
  // link events
  input  wire                          map_response_ok,
  input  wire                          retry_limit_fail,
  input  wire [`NES_IDX_W-1:0]         event_idx,
  // transmit path lookup
  input  wire                          tx_lookup,
  input  wire [`NES_IDX_W-1:0]         tx_idx,
  output reg                           tx_valid_q,
  output reg  [`NES_ADDR_W-1:0]        tx_short_addr_q,
  output reg                           tx_scheme_q,
  output reg  [`NES_MASK_W-1:0]        tx_subcarrier_group_mask_q,
  output reg  [`NES_CONST_W-1:0]       tx_constellation_select_q,
  output reg  [`NES_GAIN_W-1:0]        tx_transmit_amplification_q,
  output reg                           tx_gain_step_resolution_q,
  output reg  [`NES_COEF_W-1:0]        tx_per_group_gain_steps_q,
  output reg  [`NES_LQI_W-1:0]         tx_return_link_quality_q,
  output reg  [`NES_PHASE_W-1:0]       tx_mains_phase_offset_q,
  output reg  [`NES_VALID_W-1:0]       tx_param_validity_minutes_q,
  output reg                           tx_map_request_q
);

  ////////////////////////////////////////////////////////////////////////////
  // write checking
  wire                       w_scheme = mgmt_wdata[`NES_F_SCHEME];
  wire [`NES_CONST_W-1:0]    w_const  = mgmt_wdata[`NES_F_CONST_LSB +: `NES_CONST_W];
  reg                        w_ok;

  // a bad entry is refused whole so the transmit path never sees it
  always @*
  begin
    w_ok = 1'b1;
    if (w_const > `NES_CONST_MAX)
      w_ok = 1'b0;
    else if ((w_const == `NES_CONST_QAM16) &&
             (!qam16_supported || (w_scheme != `NES_SCHEME_COH)))
      w_ok = 1'b0;
    else if ((w_scheme == `NES_SCHEME_COH) && !coherent_supported)
      w_ok = 1'b0;
  end

  wire wr_go = mgmt_wr && w_ok;

  ////////////////////////////////////////////////////////////////////////////
  // storage: static fields plus one countdown per entry
  wire [`NES_STATIC_W-1:0] ent_w     [0:`NES_ENTRIES-1];
  wire [`NES_VALID_W-1:0]  valid_cnt [0:`NES_ENTRIES-1];

  // field slices of the written word, shared by every entry
  wire [`NES_ADDR_W-1:0]   w_addr  = mgmt_wdata[`NES_F_ADDR_LSB +: `NES_ADDR_W];
  wire [`NES_MASK_W-1:0]   w_mask  = mgmt_wdata[`NES_F_MASK_LSB +: `NES_MASK_W];
  wire [`NES_GAIN_W-1:0]   w_gain  = mgmt_wdata[`NES_F_GAIN_LSB +: `NES_GAIN_W];
  wire                     w_res   = mgmt_wdata[`NES_F_RES];
  wire [`NES_COEF_W-1:0]   w_coef  = mgmt_wdata[`NES_F_COEF_LSB +: `NES_COEF_W];
  wire [`NES_LQI_W-1:0]    w_lqi   = mgmt_wdata[`NES_F_LQI_LSB +: `NES_LQI_W];
  wire [`NES_PHASE_W-1:0]  w_phase = mgmt_wdata[`NES_F_PHASE_LSB +: `NES_PHASE_W];

  genvar g;
  generate
    for (g = 0; g < `NES_ENTRIES; g = g + 1)
    begin : g_ent
      reg  [`NES_ADDR_W-1:0]  addr_q;
      reg                     scheme_q;
      reg  [`NES_MASK_W-1:0]  mask_q;
      reg  [`NES_CONST_W-1:0] const_q;
      reg  [`NES_GAIN_W-1:0]  gain_q;
      reg                     res_q;
      reg  [`NES_COEF_W-1:0]  coef_q;
      reg  [`NES_LQI_W-1:0]   lqi_q;
      reg  [`NES_PHASE_W-1:0] phase_q;
      wire sel_w  = wr_go && (mgmt_idx == g);
      wire sel_ev = (event_idx == g);
      wire ld     = sel_w || (map_response_ok && sel_ev);
      // creation takes the default, a plain write takes the written count
      wire [`NES_VALID_W-1:0] lv =
        sel_w ? (mgmt_create ? default_validity
                             : mgmt_wdata[`NES_F_VALID_LSB +: `NES_VALID_W])
              : map_response_lifetime;

      // one register per field; a refused write leaves every field as it was
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          addr_q <= {`NES_ADDR_W{1'b0}};
        else if (sel_w)
          addr_q <= w_addr;
      end

      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          scheme_q <= `NES_SCHEME_DIFF;
        else if (sel_w)
          scheme_q <= w_scheme;
      end

      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          mask_q <= {`NES_MASK_W{1'b0}};
        else if (sel_w)
          mask_q <= w_mask;
      end

      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          const_q <= `NES_CONST_ROBUST;
        else if (sel_w)
          const_q <= w_const;
      end

      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          gain_q <= {`NES_GAIN_W{1'b0}};
        else if (sel_w)
          gain_q <= w_gain;
      end

      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          res_q <= 1'b0;
        else if (sel_w)
          res_q <= w_res;
      end

      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          coef_q <= {`NES_COEF_W{1'b0}};
        else if (sel_w)
          coef_q <= w_coef;
      end

      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          lqi_q <= {`NES_LQI_W{1'b0}};
        else if (sel_w)
          lqi_q <= w_lqi;
      end

      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          phase_q <= {`NES_PHASE_W{1'b0}};
        else if (sel_w)
          phase_q <= w_phase;
      end

      // repacked in the management layout, lsb first
      assign ent_w[g] = {phase_q, lqi_q, coef_q, res_q, gain_q,
                         const_q, mask_q, scheme_q, addr_q};

      nes_validity u_val
      (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (ld),
        .load_val (lv),
        .fail     (retry_limit_fail && sel_ev),
        .tick     (minute_tick),
        .count_q  (valid_cnt[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // management read, one cycle latency
  reg [`NES_STATIC_W-1:0] r_ent;
  reg [`NES_VALID_W-1:0]  r_val;

  always @*
  begin
    r_ent = ent_w[0];
    r_val = valid_cnt[0];
    if (mgmt_idx == 3'h1)
    begin
      r_ent = ent_w[1];
      r_val = valid_cnt[1];
    end
    else if (mgmt_idx == 3'h2)
    begin
      r_ent = ent_w[2];
      r_val = valid_cnt[2];
    end
    else if (mgmt_idx == 3'h3)
    begin
      r_ent = ent_w[3];
      r_val = valid_cnt[3];
    end
    else if (mgmt_idx == 3'h4)
    begin
      r_ent = ent_w[4];
      r_val = valid_cnt[4];
    end
    else if (mgmt_idx == 3'h5)
    begin
      r_ent = ent_w[5];
      r_val = valid_cnt[5];
    end
    else if (mgmt_idx == 3'h6)
    begin
      r_ent = ent_w[6];
      r_val = valid_cnt[6];
    end
    else if (mgmt_idx == 3'h7)
    begin
      r_ent = ent_w[7];
      r_val = valid_cnt[7];
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mgmt_rvalid_q <= 1'b0;
      mgmt_rdata_q  <= {`NES_ENTRY_W{1'b0}};
      mgmt_reject_q <= 1'b0;
    end
    else
    begin
      mgmt_rvalid_q <= mgmt_rd;
      mgmt_reject_q <= mgmt_wr && !w_ok;
      if (mgmt_rd)
        mgmt_rdata_q <= {r_val, r_ent};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit lookup, one cycle latency
  reg [`NES_STATIC_W-1:0] t_ent;
  reg [`NES_VALID_W-1:0]  t_val;

  always @*
  begin
    t_ent = ent_w[0];
    t_val = valid_cnt[0];
    if (tx_idx == 3'h1)
    begin
      t_ent = ent_w[1];
      t_val = valid_cnt[1];
    end
    else if (tx_idx == 3'h2)
    begin
      t_ent = ent_w[2];
      t_val = valid_cnt[2];
    end
    else if (tx_idx == 3'h3)
    begin
      t_ent = ent_w[3];
      t_val = valid_cnt[3];
    end
    else if (tx_idx == 3'h4)
    begin
      t_ent = ent_w[4];
      t_val = valid_cnt[4];
    end
    else if (tx_idx == 3'h5)
    begin
      t_ent = ent_w[5];
      t_val = valid_cnt[5];
    end
    else if (tx_idx == 3'h6)
    begin
      t_ent = ent_w[6];
      t_val = valid_cnt[6];
    end
    else if (tx_idx == 3'h7)
    begin
      t_ent = ent_w[7];
      t_val = valid_cnt[7];
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_valid_q                  <= 1'b0;
      tx_short_addr_q             <= {`NES_ADDR_W{1'b0}};
      tx_scheme_q                 <= `NES_SCHEME_DIFF;
      tx_subcarrier_group_mask_q  <= {`NES_MASK_W{1'b0}};
      tx_constellation_select_q   <= `NES_CONST_ROBUST;
      tx_transmit_amplification_q <= {`NES_GAIN_W{1'b0}};
      tx_gain_step_resolution_q   <= 1'b0;
      tx_per_group_gain_steps_q   <= {`NES_COEF_W{1'b0}};
      tx_return_link_quality_q    <= {`NES_LQI_W{1'b0}};
      tx_mains_phase_offset_q     <= {`NES_PHASE_W{1'b0}};
      tx_param_validity_minutes_q <= {`NES_VALID_W{1'b0}};
      tx_map_request_q            <= 1'b0;
    end
    else
    begin
      tx_valid_q       <= tx_lookup;
      // advisory only: the mac decides whether to send the request
      tx_map_request_q <= tx_lookup && (t_val == {`NES_VALID_W{1'b0}});
      if (tx_lookup)
      begin
        tx_short_addr_q             <= t_ent[`NES_F_ADDR_LSB +: `NES_ADDR_W];
        tx_scheme_q                 <= t_ent[`NES_F_SCHEME];
        tx_subcarrier_group_mask_q  <= t_ent[`NES_F_MASK_LSB +: `NES_MASK_W];
        tx_constellation_select_q   <= t_ent[`NES_F_CONST_LSB +: `NES_CONST_W];
        tx_transmit_amplification_q <= t_ent[`NES_F_GAIN_LSB +: `NES_GAIN_W];
        tx_gain_step_resolution_q   <= t_ent[`NES_F_RES];
        tx_per_group_gain_steps_q   <= t_ent[`NES_F_COEF_LSB +: `NES_COEF_W];
        tx_return_link_quality_q    <= t_ent[`NES_F_LQI_LSB +: `NES_LQI_W];
        tx_mains_phase_offset_q     <= t_ent[`NES_F_PHASE_LSB +: `NES_PHASE_W];
        tx_param_validity_minutes_q <= t_val;
      end
    end
  end
endmodule

// ===== src/nes_validity.v
// per-entry validity countdown in minutes
`timescale 1ns/1ps
`include "nes_consts.vh"
module nes_validity
(
  // clock and reset
  input  wire                       clk,
  input  wire                       rst_n,
  // events, priority: fail, load, tick
  input  wire                       load,
  input  wire [`NES_VALID_W-1:0]    load_val,
  input  wire                       fail,
  input  wire                       tick,
  // state
  output reg  [`NES_VALID_W-1:0]    count_q
);
  reg [`NES_VALID_W-1:0] count_d;

  always @*
  begin
    count_d = count_q;
    if (fail)
      count_d = {`NES_VALID_W{1'b0}};
    else if (load)
      count_d = load_val;
    else if (tick && (count_q != {`NES_VALID_W{1'b0}}))
      count_d = count_q - {{(`NES_VALID_W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= {`NES_VALID_W{1'b0}};
    else
      count_q <= count_d;
  end
endmodule
